// ===== key_checker.sv
// file: two-byte ordered key sequence checker
// assumes: one write strobe per key byte, inputs synchronous to pclk
module key_checker
  import otp_unlock_pkg::*;
#(
  parameter logic [7:0] KEY_FIRST  = KEY_FIRST_DEF,
  parameter logic [7:0] KEY_SECOND = KEY_SECOND_DEF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       key_write,
  input  wire logic       other_write,
  input  wire logic [7:0] unlock_key_bits,
  output logic            key_half,
  output logic            write_grant
);

  key_state_t state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= KEY_IDLE;
    end else if (key_write) begin
      unique case (state)
        KEY_IDLE: begin
          state <= (unlock_key_bits == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
        KEY_HALF: begin
          if (unlock_key_bits == KEY_SECOND) begin
            state <= KEY_OPEN;
          end else if (unlock_key_bits == KEY_FIRST) begin
            state <= KEY_HALF;
          end else begin
            state <= KEY_IDLE;
          end
        end
        KEY_OPEN: begin
          // new key write relocks and restarts the sequence
          state <= (unlock_key_bits == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        end
      endcase
    end else if (other_write && state == KEY_HALF) begin
      state <= KEY_IDLE;
    end
  end

  // no timer: half state is held indefinitely
  assign key_half    = (state == KEY_HALF);
  assign write_grant = (state == KEY_OPEN);

endmodule : key_checker

// ===== otp_unlock_and_spare_regs.sv
// file: apb register bank with reserved slot, scratch byte, otp unlock key
// assumes: apb master, zero-wait slave; otp array outside takes otp_wr_*
// assumes: presetn is the undervoltage lockout load of all defaults
//
// Added by the designer: register access over APB.
module otp_unlock_and_spare_regs
  import otp_unlock_pkg::*;
#(
  parameter logic [7:0] KEY_FIRST  = KEY_FIRST_DEF,
  parameter logic [7:0] KEY_SECOND = KEY_SECOND_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             otp_wr_en,
  output logic [7:0]       otp_wr_data,
  output logic             otp_write_grant
);

  // ---------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------
  logic [7:0] index;
  logic       word_ok;
  logic       access;
  logic       any_write;
  logic       wr;
  logic       lane0;
  logic       read_setup;
  logic       mapped;

  assign index      = paddr[9:2];
  // words only: byte offset and high address bits must be clear
  assign word_ok    = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
  assign access     = psel && penable;
  assign any_write  = access && pwrite;
  assign wr         = any_write && word_ok;
  assign lane0      = pstrb[0];
  assign read_setup = psel && !penable && !pwrite;

  // only the five words of this bank answer without error
  always_comb begin
    mapped = 1'b0;
    if (word_ok) begin
      unique case (index)
        IDX_RESERVED_D: mapped = 1'b1;
        IDX_SCRATCH:    mapped = 1'b1;
        IDX_UNLOCK_KEY: mapped = 1'b1;
        IDX_OTP_STATUS: mapped = 1'b1;
        IDX_OTP_WRITE:  mapped = 1'b1;
        default:        mapped = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // bus response
  // ---------------------------------------------------------------------
  // zero wait states; unmapped or misaligned words error and store nothing; an errored write still breaks a pending key
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ---------------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------------
  logic key_write;
  logic other_write;
  logic scratch_write;
  logic status_write;
  logic blocked_clear;
  logic otp_attempt;
  logic otp_granted;
  logic otp_refused;

  assign key_write     = wr && lane0 && index == IDX_UNLOCK_KEY;
  // any other write, even errored or strobeless, breaks a pending key
  assign other_write   = any_write && !key_write;
  assign scratch_write = wr && lane0 && index == IDX_SCRATCH;
  assign status_write  = wr && lane0 && index == IDX_OTP_STATUS;
  assign blocked_clear = status_write && pwdata[STATUS_BLOCKED_BIT];
  assign otp_attempt   = wr && lane0 && index == IDX_OTP_WRITE;
  // an otp port write with lane 0 strobed either passes with the qualifier or is refused
  assign otp_granted   = otp_attempt && otp_write_grant;
  assign otp_refused   = otp_attempt && !otp_write_grant;

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [7:0] scratch_byte;
  logic [7:0] otp_unlock_key;
  logic       blocked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_byte <= SCRATCH_RESET;
    end else if (scratch_write) begin
      scratch_byte <= pwdata[7:0];
    end
  end

  // write-only key byte: kept, never read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_unlock_key <= UNLOCK_RESET;
    end else if (key_write) begin
      otp_unlock_key <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // key sequence
  // ---------------------------------------------------------------------
  // half-key state, also shown in the status word
  logic key_half;

  // grant is the checker's decoded state, so it needs no extra flop
  key_checker #(
    .KEY_FIRST  (KEY_FIRST),
    .KEY_SECOND (KEY_SECOND)
  ) u_key_checker (
    .pclk            (pclk),
    .presetn         (presetn),
    .key_write       (key_write),
    .other_write     (other_write),
    .unlock_key_bits (pwdata[7:0]),
    .key_half        (key_half),
    .write_grant     (otp_write_grant)
  );

  // ---------------------------------------------------------------------
  // otp write gate
  // ---------------------------------------------------------------------
  // one-cycle pulse per granted write, never without the qualifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_wr_en <= 1'b0;
    end else begin
      otp_wr_en <= otp_granted;
    end
  end

  // data holds the last granted byte between pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_wr_data <= OTP_DATA_RESET;
    end else if (otp_granted) begin
      otp_wr_data <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // status flag
  // ---------------------------------------------------------------------
  // sticky blocked flag, set wins over clear by status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocked <= 1'b0;
    end else if (otp_refused) begin
      blocked <= 1'b1;
    end else if (blocked_clear) begin
      blocked <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word                     = READ_ZERO;
    status_word[STATUS_GRANT_BIT]   = otp_write_grant;
    status_word[STATUS_HALF_BIT]    = key_half;
    status_word[STATUS_BLOCKED_BIT] = blocked;
  end

  // ---------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = READ_ZERO;
    if (word_ok) begin
      unique case (index)
        // reserved and write-only key read as zero
        IDX_RESERVED_D: next_prdata = READ_ZERO;
        IDX_SCRATCH:    next_prdata = {24'h000000, scratch_byte};
        IDX_UNLOCK_KEY: next_prdata = READ_ZERO;
        IDX_OTP_STATUS: next_prdata = status_word;
        default:        next_prdata = READ_ZERO;
      endcase
    end
  end

  // loaded in the setup cycle so the access cycle shows it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
    end else if (read_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule : otp_unlock_and_spare_regs

// ===== otp_unlock_and_spare_regs_tb.sv
// testbench: apb tests of reserved slot, scratch byte, unlock key
// assumes: package, design and checker compiled first
module otp_unlock_and_spare_regs_tb
  import otp_unlock_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, otp_wr_en, otp_write_grant, err;
  logic [7:0]  otp_wr_data;
  int          bad_count = 0, total_checks = 0, cyc = 0, pulses = 0;
  otp_unlock_and_spare_regs dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .otp_wr_en(otp_wr_en), .otp_wr_data(otp_wr_data),
    .otp_write_grant(otp_write_grant));
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    pulses += int'(otp_wr_en);
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d,
                      logic [3:0] s = 4'hF);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask : xfer
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    xfer(0, 32'h38, 0);
    cmp("scratch reset", 0, rd);
    xfer(0, 32'h3C, 0);
    cmp("key read", 0, rd);
    xfer(1, 32'h38, 32'hC3);
    xfer(1, 32'h38, 32'h5A, 4'h0);
    xfer(1, 32'h34, 32'h99);
    xfer(0, 32'h34, 0);
    cmp("reserved", 0, rd);
    cmp("reserved err", 0, err);
    xfer(0, 32'h38, 0);
    cmp("scratch", 32'hC3, rd);
    cmp("scratch err", 0, err);
    xfer(0, 32'h80, 0);
    cmp("unmapped err", 1, err);
    xfer(1, 32'h44, 32'h11);
    xfer(0, 32'h40, 0);
    cmp("blocked status", 32'h4, rd);
    cmp("blocked pulses", 0, pulses);
    xfer(1, 32'h40, 32'h4);
    xfer(0, 32'h40, 0);
    cmp("blocked clear", 0, rd);
    xfer(1, 32'h3C, KEY_FIRST_DEF);
    xfer(1, 32'h38, 32'h1);
    xfer(1, 32'h3C, KEY_SECOND_DEF);
    cmp("split key", 0, otp_write_grant);
    xfer(1, 32'h3C, KEY_FIRST_DEF);
    repeat (50) @(posedge pclk);
    xfer(0, 32'h40, 0);
    cmp("half status", 32'h2, rd);
    xfer(1, 32'h3C, KEY_SECOND_DEF);
    cmp("grant", 1, otp_write_grant);
    xfer(1, 32'h44, 32'h6E);
    xfer(0, 32'h40, 0);
    cmp("grant status", 32'h1, rd);
    cmp("otp data", 32'h6E, otp_wr_data);
    cmp("otp pulses", 1, pulses);
    xfer(1, 32'h3C, 32'h77);
    cmp("relock", 0, otp_write_grant);
    xfer(1, 32'h44, 32'h22);
    xfer(0, 32'h40, 0);
    cmp("relock status", 32'h4, rd);
    cmp("relock pulses", 1, pulses);
    xfer(1, 32'h3C, KEY_FIRST_DEF);
    xfer(1, 32'h3C, KEY_FIRST_DEF);
    xfer(1, 32'h3C, KEY_SECOND_DEF);
    cmp("restart", 1, otp_write_grant);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    cmp("reset grant", 0, otp_write_grant);
    xfer(0, 32'h38, 0);
    cmp("reset scratch", 0, rd);
    xfer(0, 32'h40, 0);
    cmp("reset status", 0, rd);
    print_verdict();
  end
endmodule : otp_unlock_and_spare_regs_tb

// ===== otp_unlock_assertions.sv
// checker: port properties of the unlock bank
// assumes: bound to the bank top, zero-wait apb
module otp_unlock_chk
  import otp_unlock_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        otp_wr_en,
  input wire logic [7:0]  otp_wr_data,
  input wire logic        otp_write_grant
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr  = acc && pwrite && pstrb[0];
  wire logic rd  = acc && !pwrite;
  wire logic kw  = wr && paddr == 32'h3C;
  chk_rsvd_reads_zero:
    assert property (rd && paddr == 32'h34 |-> prdata == READ_ZERO)
    else $error("reserved read not zero");
  chk_key_reads_zero:
    assert property (rd && paddr == 32'h3C |-> prdata == READ_ZERO)
    else $error("key read not zero");
  chk_scratch_no_err:
    assert property (acc && paddr == 32'h38 |-> pready && !pslverr)
    else $error("scratch access errored");
  chk_grant_by_key:
    assert property ($rose(otp_write_grant) |->
      $past(kw && pwdata[7:0] == KEY_SECOND_DEF))
    else $error("grant without second key byte");
  chk_key_relocks:
    assert property (kw && otp_write_grant |=> !otp_write_grant)
    else $error("key write left grant");
  chk_grant_kept:
    assert property (otp_write_grant && !kw |=> otp_write_grant)
    else $error("grant lost");
  chk_otp_blocked:
    assert property (otp_wr_en |-> $past(otp_write_grant))
    else $error("otp write without grant");
  chk_otp_pulse:
    assert property (wr && paddr == 32'h44 && otp_write_grant |=>
      otp_wr_en && otp_wr_data == $past(pwdata[7:0]) ##1 !otp_wr_en)
    else $error("otp write pulse wrong");
  cover property ($rose(otp_write_grant));
  cover property (otp_wr_en);
  cover property (acc && pslverr);
endmodule : otp_unlock_chk

bind otp_unlock_and_spare_regs otp_unlock_chk chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .otp_wr_en(otp_wr_en),
  .otp_wr_data(otp_wr_data), .otp_write_grant(otp_write_grant));

// ===== otp_unlock_pkg.sv
// package: register map, reset values and key constants for the unlock bank
// assumes: 32-bit apb, printed offsets are register indexes (not multiples of 4)
package otp_unlock_pkg;

  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  IDX_RESERVED_D = 8'h0D;
  localparam logic [7:0]  IDX_SCRATCH    = 8'h0E;
  localparam logic [7:0]  IDX_UNLOCK_KEY = 8'h0F;
  localparam logic [7:0]  IDX_OTP_STATUS = 8'h10;
  localparam logic [7:0]  IDX_OTP_WRITE  = 8'h11;
  localparam logic [7:0]  SCRATCH_RESET  = 8'h00;
  localparam logic [7:0]  UNLOCK_RESET   = 8'h00;
  localparam logic [7:0]  OTP_DATA_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO      = 32'h00000000;
  // key bytes: values arbitrary, overridable by parameter
  localparam logic [7:0]  KEY_FIRST_DEF  = 8'hA5;
  localparam logic [7:0]  KEY_SECOND_DEF = 8'h5A;
  localparam int          STATUS_GRANT_BIT   = 0;
  localparam int          STATUS_HALF_BIT    = 1;
  localparam int          STATUS_BLOCKED_BIT = 2;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_HALF,
    KEY_OPEN
  } key_state_t;

endpackage : otp_unlock_pkg
